/* hw/twbm_pkg.sv */
// Constants for the two-wire byte master: register map, fields, timing.
// Assumes a 25 MHz aclk and an AXI4-Lite master with 32-bit data.
package twbm_pkg;
	// Bus geometry
	localparam int AXI_AW = 18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_RATE = 16'h7fa4;
	localparam logic [15:0] IDX_CTRL = 16'h7fa5;
	localparam logic [15:0] IDX_DATA = 16'h7fa6;
	localparam logic [15:0] IDX_MODE = 16'h7fa7;
	// Control/status, mode and rate field positions
	localparam int CS_START = 7;
	localparam int CS_STOP = 6;
	localparam int CS_FINAL = 5;
	localparam int MODE_STOP_IRQ_ENABLE = 1;
	localparam int RATE_FAST = 0;
	// Reset values
	localparam logic [7:0] CS_RST = 8'h00;
	localparam logic MODE_STOP_IRQ_ENABLE_RST = 1'b0;
	localparam logic RATE_FAST_RST = 1'b0;
	// Timing: quarter of a bus bit, rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 40;
	localparam int STD_PERIOD_NS = 10000;
	localparam int FAST_PERIOD_NS = 2500;
	localparam int QTR_W = 7;
	localparam int Q_STD_CYC =
		(STD_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int Q_FAST_CYC =
		(FAST_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Engine states
	typedef enum logic [2:0] {
		ST_IDLE, ST_HOLD, ST_START, ST_BIT, ST_STOP
	} twbm_state_t;
endpackage

/* hw/twbm_top.sv */
// Two-wire byte master with an AXI4-Lite register port.
// Assumes open-drain pins resolved outside; pin inputs are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module twbm_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [twbm_pkg::AXI_AW-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [twbm_pkg::AXI_AW-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Two-wire pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Boot loader findings and interrupt
	input wire logic [1:0] boot_prom_kind,
	output logic third_external_irq
);
	import twbm_pkg::*;

	// Index match on a byte address
	function automatic logic hit(input logic [AXI_AW-1:0] a,
		input logic [15:0] idx);
		return a[AXI_AW-1:2] == idx;
	endfunction

	twbm_state_t state;
	logic [1:0] qph;
	logic [3:0] bitn;
	logic [7:0] shreg;
	logic rd_mode, ack_smp, addr_byte, rx_byte;
	logic scl_m, scl_s, sda_m, sda_s;
	logic [1:0] kind_m, kind_s;
	logic start, stop, final_read, bus_fault, ack, done;
	logic stop_irq_enable, rate_fast;
	logic [QTR_W-1:0] qcnt;
	logic tick;
	logic aw_full, w_full, wstrb0;
	logic [AXI_AW-1:0] aw_q;
	logic [7:0] wd_q;

	// Pins cross into aclk through two flops each
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{scl_m, scl_s, sda_m, sda_s} <= 4'hf;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			sda_m <= sda_in;
			sda_s <= sda_m;
		end
	end

	// Boot findings keep moving during reset, so the field
	// is settled by the first read after release
	always_ff @(posedge aclk) begin
		kind_m <= boot_prom_kind;
		kind_s <= kind_m;
	end

	// Open drain: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// Quarter-bit divider; rate picked by software
	logic [QTR_W-1:0] qlast;
	assign qlast = rate_fast ? QTR_W'(Q_FAST_CYC - 1) :
		QTR_W'(Q_STD_CYC - 1);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			qcnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= qcnt == qlast;
			qcnt <= (qcnt >= qlast) ? '0 : qcnt + 1'b1;
		end
	end

	// Write side decode
	logic wr_go, aw_ctrl, aw_data, aw_mode, aw_rate, aw_ok;
	assign wr_go = aw_full && w_full && !bvalid;
	assign aw_ctrl = hit(aw_q, IDX_CTRL);
	assign aw_data = hit(aw_q, IDX_DATA);
	assign aw_mode = hit(aw_q, IDX_MODE);
	assign aw_rate = hit(aw_q, IDX_RATE);
	assign aw_ok = aw_ctrl | aw_data | aw_mode | aw_rate;

	// Read side decode
	logic ar_go, ar_ctrl, ar_data, ar_mode, ar_rate;
	logic [7:0] cs_val, rd_val;
	assign ar_go = arvalid && arready;
	assign ar_ctrl = hit(araddr, IDX_CTRL);
	assign ar_data = hit(araddr, IDX_DATA);
	assign ar_mode = hit(araddr, IDX_MODE);
	assign ar_rate = hit(araddr, IDX_RATE);
	assign cs_val = {start, stop, final_read, kind_s,
		bus_fault, ack, done};
	assign rd_val = ar_ctrl ? cs_val :
		ar_data ? shreg :
		ar_mode ? {6'h00, stop_irq_enable, 1'b0} :
		ar_rate ? {7'h00, rate_fast} : 8'h00;

	// Writes land only when lane 0 is strobed
	logic cs_wr, data_wr, data_rd, data_touch;
	assign cs_wr = wr_go && aw_ctrl && wstrb0;
	assign data_wr = wr_go && aw_data && wstrb0;
	assign data_rd = ar_go && ar_data;
	assign data_touch = data_rd || (wr_go && aw_data);

	// AXI handshakes: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_q <= '0;
			wd_q <= 8'h00;
			wstrb0 <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_q <= awaddr;
				aw_full <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wd_q <= wdata[7:0];
				wstrb0 <= wstrb[0];
				w_full <= 1'b1;
				wready <= 1'b0;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid <= 1'b1;
				bresp <= aw_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Read answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (ar_go) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h00_0000, rd_val};
			rresp <= (ar_ctrl | ar_data | ar_mode | ar_rate) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Engine events
	logic busy, step, ack_begin, ack_end, stop_end, fault_set;
	logic own_hi, bit_rel, launch;
	assign busy = state == ST_START || state == ST_BIT ||
		state == ST_STOP;
	// A stretched clock holds the phase count
	assign step = tick && busy && !(scl_oe_n && !scl_s);
	assign ack_begin = step && state == ST_BIT && bitn == 4'h8 &&
		qph == 2'h0;
	assign ack_end = step && state == ST_BIT && bitn == 4'h8 &&
		qph == 2'h3;
	assign stop_end = step && state == ST_STOP && qph == 2'h3;
	// The byte after a start is the address; we always send it
	assign rx_byte = rd_mode && !addr_byte;
	assign own_hi = bitn != 4'h8 && !rx_byte && shreg[7];
	// Lost arbitration or a stray low while we float high
	assign fault_set = step && state == ST_BIT && qph == 2'h2 &&
		own_hi && !sda_s;
	// Ack bit: master acks reads unless final
	assign bit_rel = bitn == 4'h8 ? (!rx_byte || final_read) :
		(rx_byte || shreg[7]);
	assign launch = (state == ST_IDLE || state == ST_HOLD) &&
		(data_wr || (data_rd && rd_mode && !stop));

	// Flag next values; hardware set wins over clear
	logic next_start, next_stop, next_final, next_fault, next_done;
	logic next_irq;
	assign next_start = cs_wr ? wd_q[CS_START] :
		start && !ack_begin;
	assign next_stop = cs_wr ? wd_q[CS_STOP] :
		stop && !stop_end;
	assign next_final = cs_wr ? wd_q[CS_FINAL] :
		final_read && !ack_end;
	assign next_fault = fault_set || (bus_fault && !data_touch);
	assign next_done = ack_end || (done && !data_touch);
	assign next_irq = ack_end || (stop_end && stop_irq_enable) ||
		(third_external_irq && !data_touch);

	// Software-visible flags and mode bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{start, stop, final_read} <= CS_RST[7:5];
			{bus_fault, ack, done} <= CS_RST[2:0];
			third_external_irq <= 1'b0;
			stop_irq_enable <= MODE_STOP_IRQ_ENABLE_RST;
			rate_fast <= RATE_FAST_RST;
		end else begin
			start <= next_start;
			stop <= next_stop;
			final_read <= next_final;
			bus_fault <= next_fault;
			done <= next_done;
			third_external_irq <= next_irq;
			if (ack_end)
				ack <= !ack_smp;
			if (wr_go && aw_mode && wstrb0)
				stop_irq_enable <= wd_q[MODE_STOP_IRQ_ENABLE];
			if (wr_go && aw_rate && wstrb0)
				rate_fast <= wd_q[RATE_FAST];
		end
	end

	// Bit engine: q0 sets SDA, q1 lifts SCL, q2 samples, q3 drops SCL
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			qph <= 2'h0;
			bitn <= 4'h0;
			shreg <= 8'h00;
			rd_mode <= 1'b0;
			addr_byte <= 1'b0;
			ack_smp <= 1'b1;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end else if (launch) begin
			if (data_wr)
				shreg <= wd_q;
			if (data_wr && start)
				rd_mode <= wd_q[0];
			// Marks the byte sent after a start condition
			addr_byte <= start;
			state <= start ? ST_START : ST_BIT;
			qph <= 2'h0;
			bitn <= 4'h0;
		end else if (fault_set) begin
			state <= ST_IDLE;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end else if (step) begin
			qph <= qph + 2'h1;
			unique case (state)
			ST_START: begin
				if (qph == 2'h0)
					sda_oe_n <= 1'b1;
				if (qph == 2'h1)
					scl_oe_n <= 1'b1;
				if (qph == 2'h2)
					sda_oe_n <= 1'b0;
				if (qph == 2'h3) begin
					scl_oe_n <= 1'b0;
					state <= ST_BIT;
				end
			end
			ST_BIT: begin
				if (qph == 2'h0)
					sda_oe_n <= bit_rel;
				if (qph == 2'h1)
					scl_oe_n <= 1'b1;
				if (qph == 2'h2 && bitn == 4'h8)
					ack_smp <= sda_s;
				if (qph == 2'h2 && bitn != 4'h8)
					shreg <= {shreg[6:0], sda_s};
				if (qph == 2'h3) begin
					scl_oe_n <= 1'b0;
					bitn <= bitn + 4'h1;
					// Only stop or a bus fault ends a transfer
					if (bitn == 4'h8)
						state <= stop ? ST_STOP : ST_HOLD;
				end
			end
			ST_STOP: begin
				if (qph == 2'h0)
					scl_oe_n <= 1'b0;
				if (qph == 2'h1)
					sda_oe_n <= 1'b0;
				if (qph == 2'h2)
					scl_oe_n <= 1'b1;
				if (qph == 2'h3) begin
					sda_oe_n <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: ;
			endcase
		end else if (stop && !busy) begin
			state <= ST_STOP;
			qph <= 2'h0;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence ack_close;
		state == ST_BIT && bitn == 4'h8 && step && qph == 2'h3;
	endsequence
	sequence hold_stop;
		state == ST_HOLD && stop && !launch && !fault_set;
	endsequence

	done_irq_a: assert property ($rose(done) |-> third_external_irq)
		else $error("done rose without irq");
	start_clear_a: assert property (state == ST_BIT && bitn == 4'h8 &&
		qph == 2'h1 && !$past(cs_wr) |-> !start)
		else $error("start not cleared in ack");
	stop_clear_a: assert property ($fell(stop) && !$past(cs_wr) |->
		$past(state) == ST_STOP && state == ST_IDLE)
		else $error("stop fell outside stop end");
	stop_now_a: assert property (hold_stop |=> state == ST_STOP)
		else $error("stop not started from hold");
	read_ack_a: assert property (state == ST_BIT && bitn == 4'h8 &&
		qph == 2'h2 && rx_byte |-> sda_oe_n == final_read)
		else $error("read ack level wrong");
	final_clr_a: assert property (ack_close ##1 !$past(cs_wr) |->
		!final_read && done)
		else $error("final or done wrong after ack");
	fault_clr_a: assert property (data_touch && !fault_set |=>
		!bus_fault)
		else $error("fault not cleared by data access");
	ack_upd_a: assert property ($changed(ack) |-> $rose(done))
		else $error("ack changed without done");
	done_clr_a: assert property (data_touch && !ack_end |=> !done)
		else $error("done not cleared by data access");
	stop_irq_a: assert property (stop_end && stop_irq_enable |=>
		third_external_irq)
		else $error("stop irq missing");
	sda_low_a: assert property (state == ST_BIT &&
		$changed(sda_oe_n) |-> !scl_oe_n)
		else $error("sda moved with scl high");
	rate_def_a: assert property (tick && !$past(rate_fast) |->
		$past(qcnt) == QTR_W'(Q_STD_CYC - 1))
		else $error("standard rate count wrong");
endmodule
`default_nettype wire

/* tb/twbm_slave.sv */
// Two-wire slave model: acks writes, sends byte TX on reads.
// Assumes the bench resolves open-drain lines with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module twbm_slave #(parameter logic [7:0] TX = 8'h5a) (
	// Bus lines and control
	input wire logic scl,
	input wire logic sda,
	input wire logic nak,
	output logic sda_oe_n,
	output logic [7:0] seen,
	output logic mnak
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00;
	logic rd = 1'b0;
	logic first = 1'b0;
	initial sda_oe_n = 1'b1;
	// Start or stop: data moving while the clock is high
	always @(sda) begin
		if (scl) begin
			cnt = 4'h0;
			rd = 1'b0;
			first = !sda;
		end
	end
	// Sample on the rising clock, msb first
	always @(posedge scl) begin
		if (cnt == 4'h8) begin
			cnt = 4'h0;
			mnak = sda;
			if (first)
				rd = sh[0];
			else if (sda)
				rd = 1'b0; // Master refused more data
			first = 1'b0;
		end else begin
			sh = {sh[6:0], sda};
			cnt = cnt + 4'h1;
			seen = sh;
		end
	end
	// Change the line only while the clock is low
	always @(negedge scl) begin
		if (cnt == 4'h8)
			sda_oe_n = rd | nak;
		else
			sda_oe_n = !rd | TX[3'h7 - cnt[2:0]];
	end
endmodule
`default_nettype wire

/* tb/test_two_wire_byte_master.sv */
// Bench for the two-wire byte master, driven over AXI4-Lite.
// Assumes the slave model on a pulled-up open-drain bus.
`timescale 1ns/1ns
`default_nettype none
module test_two_wire_byte_master;
	import twbm_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, v;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, br;
	logic [31:0] rdata;
	logic scl_oe_n, sda_oe_n, s_oe_n, mnak;
	logic nak = 1'b0, jam = 1'b0;
	logic [7:0] seen;
	logic [1:0] kind = 2'h2;
	wire scl_w = scl_oe_n;
	wire sda_w = sda_oe_n & s_oe_n & !jam;
	int num_checks = 0, n_fail = 0, n;
	twbm_top twbm_top_i (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.scl_in(scl_w), .scl_out(), .scl_oe_n(scl_oe_n),
		.sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n),
		.boot_prom_kind(kind), .third_external_irq(irq));
	twbm_slave twbm_slave_i (.scl(scl_w), .sda(sda_w), .nak(nak),
		.sda_oe_n(s_oe_n), .seen(seen), .mnak(mnak));
	always #20 aclk = ~aclk;
	function automatic logic [31:0] cs(input logic [2:0] lo);
		return {27'h0, kind, lo};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Address and data offered together, each dropped once taken
	// Each task returns only after its answer, spacing accesses
	task automatic wr(input logic [15:0] i, input logic [7:0] d);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				a = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		br = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] i, output logic [31:0] d);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= {i, 2'h0};
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = (rresp === RESP_OKAY) ? rdata : 32'hdead;
		rready <= 1'b0;
	endtask
	task automatic wait_irq();
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (irq !== 1'b1);
	endtask
	task automatic t_reset();
		rd(IDX_CTRL, v); chk(v, cs(3'h0));
		rd(IDX_MODE, v); chk(v, 32'h0);
		rd(IDX_RATE, v); chk(v, 32'h0);
		wr(IDX_CTRL, 8'h1f); chk(br, RESP_OKAY);
		rd(IDX_CTRL, v); chk(v, cs(3'h0));
		rd(16'h0010, v); chk(v, 32'hdead);
		wr(16'h0010, 8'h00); chk(br, RESP_SLVERR);
		chk(irq, 1'b0);
		$display("done: reset values");
	endtask
	task automatic t_write();
		wr(IDX_CTRL, 8'h80);
		wr(IDX_DATA, 8'ha4);
		wait_irq();
		chk(n > 36 * Q_STD_CYC && n < 41 * Q_STD_CYC, 1);
		rd(IDX_CTRL, v); chk(v, cs(3'h3));
		chk(seen, 8'ha4);
		rd(IDX_DATA, v); chk(v, 32'ha4);
		chk(irq, 1'b0);
		rd(IDX_CTRL, v); chk(v, cs(3'h2));
		$display("done: write byte");
	endtask
	task automatic t_nak();
		nak <= 1'b1;
		wr(IDX_DATA, 8'h3c);
		wait_irq();
		rd(IDX_CTRL, v); chk(v, cs(3'h1));
		chk(seen, 8'h3c);
		nak <= 1'b0;
		rd(IDX_DATA, v);
		$display("done: refused byte");
	endtask
	task automatic t_stop();
		wr(IDX_MODE, 8'h02);
		rd(IDX_MODE, v); chk(v, 32'h2);
		wr(IDX_CTRL, 8'h40);
		wait_irq();
		chk(n < 6 * Q_STD_CYC, 1);
		rd(IDX_CTRL, v); chk(v, cs(3'h0));
		chk({scl_w, sda_w}, 2'h3);
		rd(IDX_DATA, v);
		chk(irq, 1'b0);
		wr(IDX_MODE, 8'h00);
		$display("done: stop");
	endtask
	task automatic t_read();
		wr(IDX_RATE, 8'h01);
		wr(IDX_CTRL, 8'h80);
		wr(IDX_DATA, 8'ha5);
		wait_irq();
		chk(n > 36 * Q_FAST_CYC && n < 41 * Q_FAST_CYC, 1);
		rd(IDX_DATA, v); chk(v, 32'ha5);
		wait_irq();
		chk(mnak, 1'b0);
		wr(IDX_CTRL, 8'h20);
		rd(IDX_DATA, v); chk(v, 32'h5a);
		wait_irq();
		chk(mnak, 1'b1);
		rd(IDX_CTRL, v); chk(v & 32'hfd, cs(3'h1));
		wr(IDX_CTRL, 8'h40);
		do rd(IDX_CTRL, v); while (v[6]);
		wr(IDX_RATE, 8'h00);
		$display("done: read bytes");
	endtask
	task automatic t_fault();
		jam <= 1'b1;
		wr(IDX_CTRL, 8'h80);
		wr(IDX_DATA, 8'hff);
		for (int k = 0; k < 300 && !v[2]; k++)
			rd(IDX_CTRL, v);
		chk(v[2], 1'b1);
		jam <= 1'b0;
		rd(IDX_DATA, v);
		rd(IDX_CTRL, v); chk(v[2], 1'b0);
		$display("done: bus fault");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_write();
		t_nak();
		t_stop();
		t_read();
		t_fault();
		close_out();
	end
	// Watchdog: the run needs well under 30000 cycles
	initial begin
		#1200000;
		n_fail++;
		close_out();
	end
endmodule
`default_nettype wire
